// ==== core/pci_cfg_intack_vector.sv ====
// Purpose: Register channel turning local accesses into PCI config and intack cycles
// Assumes: Simple local-bus slave port and a simple PCI master request port
// Notes:   Delayed transfers answer with retry until the PCI side completes
// How it works
// - Type bit set gives a Type 1 cycle carrying the full address register.
// - Type bit clear gives a Type 0 cycle with one upper AD line asserted.
// - Device select n drives only AD line 16+n.
// - Type 0 drives AD15:11 zero, function, register number, AD1:0 zero.
// - Address register bit 15 always reads and acts as zero.
// - Local write or read of data register launches config write or read.
// - PCI-side writes of data register ignored, reads return zero.
// - Config cycles run delayed; local access completes after PCI cycle.
// - Register data passes without byte swapping.
// - Data register access with master enable clear ends in bus error.
// - Vector register access with master enable clear ends in bus error.
// - Vector read launches intack with byte enables from size and address.
// - Intack cycle carries the local access address.
// - Vector read retried until data latched, then returns captured vector.
// - Vector register writes ignored; PCI-side reads return zero.
// - Packet pointer keeps bits 31:4, reloaded on each fetched packet.
// - Interrupt flags stick until software writes one, except bits 13 and 11:8, which follow the level inputs; source untouched.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_gen_regs.svh"
module pci_cfg_intack_vector (
    input  wire logic        REF_CLK_I,        // Bridge clock, 25 MHz
    input  wire logic        NRST_I,           // Global reset, active low
    input  wire logic        LB_REQ_I,         // Local access strobe
    input  wire logic        LB_WR_I,          // Local access is a write
    input  wire logic [31:0] LB_ADDR_I,        // Local byte address
    input  wire logic [1:0]  LB_SIZE_I,        // Local size lines
    input  wire logic [31:0] LB_WDATA_I,       // Local write data
    output logic             LB_ACK_O,         // Local access done
    output logic             LB_RETRY_O,       // Local access retried
    output logic             LB_BERR_O,        // Local access bus error
    output logic [31:0]      LB_RDATA_O,       // Local read data
    input  wire logic        PR_REQ_I,         // PCI-side register access strobe
    input  wire logic        PR_WR_I,          // PCI-side access is a write
    input  wire logic [11:0] PR_ADDR_I,        // PCI-side register offset
    input  wire logic [31:0] PR_WDATA_I,       // PCI-side write data
    output logic             PR_ACK_O,         // PCI-side access done
    output logic [31:0]      PR_RDATA_O,       // PCI-side read data
    input  wire logic        MASTER_EN_I,      // PCI master enable bit
    output logic             PCI_REQ_O,        // PCI cycle request, held until done
    output logic [3:0]       PCI_CMD_O,        // PCI bus command
    output logic [31:0]      PCI_ADDR_O,       // Address phase value
    output logic [3:0]       PCI_BE_O,         // Byte enables, active high
    output logic [31:0]      PCI_WDATA_O,      // Write data phase value
    input  wire logic        PCI_DONE_I,       // PCI cycle finished, one pulse
    input  wire logic [31:0] PCI_RDATA_I,      // Read data with done
    input  wire logic        PKT_LOAD_I,       // Command packet fetched, one pulse
    input  wire logic [31:0] PKT_NEXT_I,       // Next packet address from it
    input  wire logic [31:0] INT_EVENT_I,      // Interrupt condition pulses
    input  wire logic [31:0] INT_LEVEL_I,      // Read-only status levels
    output logic [31:0]      INT_FLAGS_O       // Interrupt flag register
);
    typedef struct packed {
        logic [31:0]              cfg_addr;
        logic [31:0]              cfg_data;
        logic [31:0]              vector;
        logic [31:0]              pkt_ptr;
        logic [31:0]              flags;
        cfg_gen_pkg::xfer_kind_t  kind;
        logic                     done;
        logic [31:0]              owner_addr;
        logic                     pci_req;
        logic [3:0]               pci_cmd;
        logic [31:0]              pci_addr;
        logic [3:0]               pci_be;
        logic [31:0]              pci_wdata;
        logic                     lb_ack;
        logic                     lb_retry;
        logic                     lb_berr;
        logic [31:0]              lb_rdata;
        logic                     pr_ack;
        logic [31:0]              pr_rdata;
    } state_t;

    state_t q;
    state_t d;
    pci_cycle_if cyc ();

    ////////////////////////////////////////////////////////////////////////
    // Address former sees the live register, so a pending cycle latches it
    assign cyc.cfg_addr   = q.cfg_addr;
    assign cyc.is_intack  = (LB_ADDR_I[11:0] == `OFF_INTACK);
    assign cyc.local_addr = LB_ADDR_I;
    pci_addr_former u_fmt (
        .cyc (cyc.fmt)
    );

    // Byte enables from size lines and low address bits (00 means 4 bytes)
    function automatic logic [3:0] lane_enables(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] m;
        m = 4'h0;
        case (sz)
            2'h1:    m = 4'h1 << a;
            2'h2:    m = a[1] ? 4'hc : 4'h3;
            2'h3:    m = a[0] ? 4'he : 4'h7;
            default: m = 4'hf;
        endcase
        return m;
    endfunction

    logic        lb_cfg_data;
    logic        lb_intack;
    logic        same_owner;
    logic [31:0] flag_clr;
    assign lb_cfg_data = LB_ADDR_I[11:0] == `OFF_CFG_DATA;
    assign lb_intack   = LB_ADDR_I[11:0] == `OFF_INTACK;
    assign same_owner  = LB_ADDR_I == q.owner_addr;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        d.lb_ack   = 1'b0;
        d.lb_retry = 1'b0;
        d.lb_berr  = 1'b0;
        d.pr_ack   = 1'b0;
        flag_clr   = 32'h0;
        // PCI cycle completion latches data and frees the request
        if (q.pci_req && PCI_DONE_I) begin
            d.pci_req = 1'b0;
            d.done    = 1'b1;
            if (q.kind == cfg_gen_pkg::XFER_CFG_RD) begin
                d.cfg_data = PCI_RDATA_I;
            end
            if (q.kind == cfg_gen_pkg::XFER_INTACK) begin
                d.vector = PCI_RDATA_I;
            end
        end
        // Local-bus slave
        if (LB_REQ_I) begin
            if ((lb_cfg_data || lb_intack) && !MASTER_EN_I) begin
                d.lb_berr = 1'b1;
            end else if (lb_intack && LB_WR_I) begin
                d.lb_ack = 1'b1;
            end else if (lb_cfg_data || lb_intack) begin
                if (q.kind == cfg_gen_pkg::XFER_NONE) begin
                    // Launch, then retry until the PCI side completes
                    d.lb_retry   = 1'b1;
                    d.owner_addr = LB_ADDR_I;
                    d.pci_req    = 1'b1;
                    d.pci_addr   = cyc.pci_addr;
                    d.pci_wdata  = LB_WDATA_I;
                    d.done       = 1'b0;
                    if (lb_intack) begin
                        d.kind    = cfg_gen_pkg::XFER_INTACK;
                        d.pci_cmd = `CMD_INTACK;
                        d.pci_be  = lane_enables(LB_SIZE_I, LB_ADDR_I[1:0]);
                    end else begin
                        d.kind    = LB_WR_I ? cfg_gen_pkg::XFER_CFG_WR : cfg_gen_pkg::XFER_CFG_RD;
                        d.pci_cmd = LB_WR_I ? `CMD_CFG_WR : `CMD_CFG_RD;
                        d.pci_be  = 4'hf;
                        if (LB_WR_I) begin
                            d.cfg_data = LB_WDATA_I;
                        end
                    end
                end else if (q.done && same_owner &&
                             ((q.kind == cfg_gen_pkg::XFER_CFG_WR) == LB_WR_I)) begin
                    // The repeated access picks up the finished result
                    d.lb_ack   = 1'b1;
                    d.lb_rdata = (q.kind == cfg_gen_pkg::XFER_INTACK) ? q.vector : q.cfg_data;
                    d.kind     = cfg_gen_pkg::XFER_NONE;
                    d.done     = 1'b0;
                end else begin
                    d.lb_retry = 1'b1;
                end
            end else begin
                d.lb_ack   = 1'b1;
                d.lb_rdata = 32'h0;
                case (LB_ADDR_I[11:0])
                    `OFF_CFG_ADDR: begin
                        if (LB_WR_I) d.cfg_addr = LB_WDATA_I & `CFG_ADDR_MASK;
                        d.lb_rdata = q.cfg_addr;
                    end
                    `OFF_PKT_PTR: begin
                        if (LB_WR_I) d.pkt_ptr = LB_WDATA_I & `PKT_PTR_MASK;
                        d.lb_rdata = q.pkt_ptr;
                    end
                    `OFF_INT_FLAGS: begin
                        if (LB_WR_I) flag_clr = LB_WDATA_I;
                        d.lb_rdata = q.flags;
                    end
                    default: d.lb_rdata = 32'h0;
                endcase
            end
        end
        // PCI-side slave: data and vector registers are dead from here
        if (PR_REQ_I) begin
            d.pr_ack   = 1'b1;
            d.pr_rdata = 32'h0;
            case (PR_ADDR_I)
                `OFF_CFG_ADDR: begin
                    if (PR_WR_I) d.cfg_addr = PR_WDATA_I & `CFG_ADDR_MASK;
                    d.pr_rdata = q.cfg_addr;
                end
                `OFF_PKT_PTR: begin
                    if (PR_WR_I) d.pkt_ptr = PR_WDATA_I & `PKT_PTR_MASK;
                    d.pr_rdata = q.pkt_ptr;
                end
                `OFF_INT_FLAGS: begin
                    if (PR_WR_I) flag_clr = flag_clr | PR_WDATA_I;
                    d.pr_rdata = q.flags;
                end
                default: d.pr_rdata = 32'h0;
            endcase
        end
        // Packet fetch overrides a same-cycle software write
        if (PKT_LOAD_I) begin
            d.pkt_ptr = PKT_NEXT_I & `PKT_PTR_MASK;
        end
        // Sticky flags: set wins over a write-one clear; levels just follow
        d.flags = (((q.flags & ~flag_clr) | INT_EVENT_I) & ~`INT_RO_MASK)
                  | (INT_LEVEL_I & `INT_RO_MASK);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q       <= '0;
            q.flags <= `INT_FLAGS_RESET;
        end else begin
            q <= d;
        end
    end

    // Every output straight from a flip-flop
    assign LB_ACK_O    = q.lb_ack;
    assign LB_RETRY_O  = q.lb_retry;
    assign LB_BERR_O   = q.lb_berr;
    assign LB_RDATA_O  = q.lb_rdata;
    assign PR_ACK_O    = q.pr_ack;
    assign PR_RDATA_O  = q.pr_rdata;
    assign PCI_REQ_O   = q.pci_req;
    assign PCI_CMD_O   = q.pci_cmd;
    assign PCI_ADDR_O  = q.pci_addr;
    assign PCI_BE_O    = q.pci_be;
    assign PCI_WDATA_O = q.pci_wdata;
    assign INT_FLAGS_O = q.flags;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_launch;
        LB_REQ_I && (LB_ADDR_I[11:0] == `OFF_CFG_DATA) && MASTER_EN_I && !q.pci_req && q.kind == cfg_gen_pkg::XFER_NONE;
    endsequence
    a_type1_addr: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (s_launch and q.cfg_addr[0]) |=> PCI_ADDR_O == $past(q.cfg_addr) && PCI_REQ_O)
        else $error("type 1 address wrong");
    a_type0_onehot: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (s_launch and !q.cfg_addr[0]) |=> $onehot(PCI_ADDR_O[31:16]) && PCI_ADDR_O[15:11] == 5'h00)
        else $error("type 0 select not one-hot");
    a_type0_lines: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (s_launch and !q.cfg_addr[0]) |=> PCI_ADDR_O[16 + $past(q.cfg_addr[14:11])] && PCI_ADDR_O[1:0] == 2'h0)
        else $error("type 0 select line wrong");
    a_bit15_zero: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        !q.cfg_addr[15])
        else $error("address bit 15 set");
    a_berr_noen: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        LB_REQ_I && (lb_cfg_data || lb_intack) && !MASTER_EN_I |=> LB_BERR_O && !PCI_REQ_O[*1])
        else $error("no bus error with master disabled");
    a_pci_side_zero: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        PR_REQ_I && (PR_ADDR_I == `OFF_CFG_DATA || PR_ADDR_I == `OFF_INTACK) |=> PR_RDATA_O == 32'h0)
        else $error("PCI-side read not zero");
    a_no_early_ack: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        PCI_REQ_O |-> !LB_ACK_O || $past(!lb_cfg_data && !(lb_intack && !LB_WR_I)))
        else $error("local ack before PCI done");
    a_pkt_reload: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        PKT_LOAD_I |=> q.pkt_ptr == ($past(PKT_NEXT_I) & `PKT_PTR_MASK))
        else $error("packet pointer not reloaded");
    a_flag_sticky: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        INT_EVENT_I[31] |=> INT_FLAGS_O[31])
        else $error("event lost");
endmodule
`default_nettype wire

// ==== core/cfg_gen_regs.svh ====
// Purpose: Offsets, field positions and reset values of the register channel
// Assumes: Byte offsets as printed; 32-bit register words
// Notes:   Definitions only
`ifndef CFG_GEN_REGS_SVH
`define CFG_GEN_REGS_SVH
`define OFF_CFG_ADDR     12'h500
`define OFF_CFG_DATA     12'h504
`define OFF_INTACK       12'h508
`define OFF_PKT_PTR      12'h414
`define OFF_INT_FLAGS    12'h600
`define OFF_MISC         12'h608
`define CFG_ADDR_MASK    32'h00ff7ffd
`define CFG_TYPE_BIT     0
`define DEV_LSB          11
`define FUNC_LSB         8
`define REG_LSB          2
`define PKT_PTR_MASK     32'hfffffff0
`define INT_FLAGS_RESET  32'h00000c00
`define INT_RO_MASK      32'h00002f00
`define CMD_CFG_RD       4'ha
`define CMD_CFG_WR       4'hb
`define CMD_INTACK       4'h0
`endif

// ==== core/cfg_gen_pkg.sv ====
// Purpose: Types shared by the register channel
// Assumes: Nothing
// Notes:   Types only
package cfg_gen_pkg;
    typedef enum logic [1:0] {
        XFER_NONE,
        XFER_CFG_RD,
        XFER_CFG_WR,
        XFER_INTACK
    } xfer_kind_t;
endpackage

// ==== core/pci_cycle_if.sv ====
// Purpose: Request and answer between transfer control and address former
// Assumes: One clock
// Notes:   Carries one delayed transfer's descriptor
`timescale 1ns/1ps
`default_nettype none
interface pci_cycle_if;
    logic [31:0] cfg_addr;
    logic        is_intack;
    logic [31:0] local_addr;
    logic [31:0] pci_addr;
    modport ctrl (output cfg_addr, output is_intack, output local_addr, input pci_addr);
    modport fmt  (input cfg_addr, input is_intack, input local_addr, output pci_addr);
endinterface
`default_nettype wire

// ==== core/pci_addr_former.sv ====
// Purpose: Forms the PCI address phase value for config and intack cycles
// Assumes: Config address already has its hardwired zero bits cleared
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cfg_gen_regs.svh"
module pci_addr_former (
    pci_cycle_if.fmt cyc    // Descriptor in, address out
);
    logic [15:0] idsel;
    ////////////////////////////////////////////////////////////////////////
    // One-hot decode of the target device select
    always_comb begin
        idsel = 16'h0000;
        idsel[cyc.cfg_addr[`DEV_LSB +: 4]] = 1'b1;
    end
    // Type 1 passes the whole register, type 0 rebuilds it
    always_comb begin
        if (cyc.is_intack) begin
            cyc.pci_addr = cyc.local_addr;
        end else if (cyc.cfg_addr[`CFG_TYPE_BIT]) begin
            cyc.pci_addr = cyc.cfg_addr;
        end else begin
            cyc.pci_addr = {idsel, 5'h00, cyc.cfg_addr[`FUNC_LSB +: 3],
                            cyc.cfg_addr[`REG_LSB +: 6], 2'h0};
        end
    end
endmodule
`default_nettype wire

// ==== testbench/pci_target_model.sv ====
// Purpose: PCI target side that answers config and intack cycles
// Assumes: Request is held until the done pulse
// Notes:   Read data lines toggle whenever no target drives them
`timescale 1ns/1ps
`default_nettype none
module pci_target_model (
    input  wire logic        clk_i,    // Bridge clock
    input  wire logic        rst_n_i,  // Reset, active low
    input  wire logic        req_i,    // Cycle request from the bridge
    input  wire logic        slow_i,   // Answer after six wait cycles
    input  wire logic [31:0] data_i,   // Value returned on reads
    output logic             done_o,   // Completion pulse
    output logic [31:0]      rdata_o   // Read data with done
);
    logic [2:0] wait_q;

    // Count wait states; a target wired to AD31..16 always answers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q  <= 3'h0;
            done_o  <= 1'b0;
            rdata_o <= 32'h0;
        end else begin
            done_o  <= 1'b0;
            rdata_o <= ~rdata_o; // Released lines must not keep the last value
            if (req_i && !done_o) begin
                if (wait_q == (slow_i ? 3'h6 : 3'h1)) begin
                    wait_q  <= 3'h0;
                    done_o  <= 1'b1;
                    rdata_o <= data_i;
                end else begin
                    wait_q <= wait_q + 3'h1;
                end
            end else begin
                wait_q <= 3'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/pci_config_iack_cycle_gen_tb_top.sv ====
// Purpose: Self-checking bench for the register channel
// Assumes: One local attempt per strobe, answer registered on the taking edge
// Notes:   Inputs change on the falling edge; seed is fixed
`timescale 1ns/1ps
`default_nettype none
`include "cfg_gen_regs.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module pci_config_iack_cycle_gen_tb_top;
    logic        clk, nrst, lb_req, lb_wr, pr_req, pr_wr, men, done, pkt_ld, slow, done_seen;
    logic        ack, rty, berr, pr_ack, preq;
    logic [31:0] lb_addr, lb_wd, pr_wd, rdata_pci, pkt_nx, ev, vec, lb_rd, pr_rd;
    logic [31:0] pci_a, pci_wd, pa, pwd, flags, av;
    logic [11:0] pr_addr;
    logic [1:0]  lb_sz;
    logic [3:0]  cmd, be, scmd, sbe;
    int          miscompares, samples_checked, seed, rc;

    pci_cfg_intack_vector DUT (
        .REF_CLK_I(clk), .NRST_I(nrst), .LB_REQ_I(lb_req), .LB_WR_I(lb_wr),
        .LB_ADDR_I(lb_addr), .LB_SIZE_I(lb_sz), .LB_WDATA_I(lb_wd), .LB_ACK_O(ack),
        .LB_RETRY_O(rty), .LB_BERR_O(berr), .LB_RDATA_O(lb_rd), .PR_REQ_I(pr_req),
        .PR_WR_I(pr_wr), .PR_ADDR_I(pr_addr), .PR_WDATA_I(pr_wd), .PR_ACK_O(pr_ack),
        .PR_RDATA_O(pr_rd), .MASTER_EN_I(men), .PCI_REQ_O(preq), .PCI_CMD_O(cmd),
        .PCI_ADDR_O(pci_a), .PCI_BE_O(be), .PCI_WDATA_O(pci_wd), .PCI_DONE_I(done),
        .PCI_RDATA_I(rdata_pci), .PKT_LOAD_I(pkt_ld), .PKT_NEXT_I(pkt_nx),
        .INT_EVENT_I(ev), .INT_LEVEL_I(`INT_FLAGS_RESET), .INT_FLAGS_O(flags));

    pci_target_model partner (.clk_i(clk), .rst_n_i(nrst), .req_i(preq), .slow_i(slow),
        .data_i(vec), .done_o(done), .rdata_o(rdata_pci));

    // 25 MHz bridge clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Remember that the far side finished, so an early ack is caught
    always @(posedge clk) if (done) done_seen <= 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Expected address phase of a config cycle from the stored register value
    function automatic logic [31:0] exp_addr(input logic [31:0] a);
        logic [31:0] m;
        m = a & `CFG_ADDR_MASK;
        if (m[0]) return m;
        return (32'h1 << (5'd16 + {1'b0, m[14:11]})) | {21'h0, m[10:2], 2'b00};
    endfunction

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One local attempt; strobe lasts one cycle, answer taken while it stands
    task automatic lb_try(input logic w, input logic [31:0] a, input logic [1:0] s,
                          input logic [31:0] d, output int code);
        lb_req = 1'b1;
        lb_wr = w;
        lb_addr = a;
        lb_sz = s;
        lb_wd = d;
        @(negedge clk);
        code = (ack === 1'b1) ? 0 : (rty === 1'b1) ? 1 : (berr === 1'b1) ? 2 : 3;
        lb_req = 1'b0;
        @(negedge clk);
    endtask

    // The master keeps coming back after each retry, within a bound
    task automatic lb_until_ack(input logic w, input logic [31:0] a, input logic [1:0] s,
                                input logic [31:0] d);
        int code;
        for (int n = 0; n < 40; n++) begin
            lb_try(w, a, s, d, code);
            if (code == 0) begin
                `CHK("ack after pci done", 1'b1, done_seen)
                return;
            end
            `CHK("retry while pending", 1, code)
        end
        miscompares++;
        conclude();
    endtask

    task automatic lb_delayed(input logic w, input logic [31:0] a, input logic [1:0] s,
                              input logic [31:0] d);
        int code;
        done_seen = 1'b0;
        lb_try(w, a, s, d, code);
        `CHK("first answer", 1, code)
        `CHK("pci request", 1'b1, preq)
        pa = pci_a;
        pwd = pci_wd;
        scmd = cmd;
        sbe = be;
        lb_until_ack(w, a, s, d);
    endtask

    // Program the address register, then run one config cycle through the data register
    task automatic cfg_cycle(input logic [31:0] a, input logic w);
        logic [31:0] d;
        int code;
        d = $random(seed);
        vec = $random(seed);
        lb_try(1'b1, 32'(`OFF_CFG_ADDR), 2'b00, a, code);
        lb_try(1'b0, 32'(`OFF_CFG_ADDR), 2'b00, 32'h0, code);
        `CHK("address readback", a & `CFG_ADDR_MASK, lb_rd)
        lb_delayed(w, 32'(`OFF_CFG_DATA), 2'b00, d);
        `CHK("address phase", exp_addr(a), pa)
        `CHK("config command", w ? `CMD_CFG_WR : `CMD_CFG_RD, scmd)
        if (w) `CHK("config write data", d, pwd)
        else `CHK("config read data", vec, lb_rd)
    endtask

    task automatic pr_access(input logic w, input logic [11:0] a);
        pr_req = 1'b1;
        pr_wr = w;
        pr_addr = a;
        pr_wd = $random(seed);
        @(negedge clk);
        `CHK("pci side ack", 1'b1, pr_ack)
        pr_req = 1'b0;
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 39352;
        men = 1'b1;
        {nrst, lb_req, lb_wr, pr_req, pr_wr, pkt_ld, slow, done_seen} = '0;
        {lb_addr, lb_wd, pr_wd, pkt_nx, ev, vec, lb_sz, pr_addr} = '0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        `CHK("flags after reset", `INT_FLAGS_RESET, flags)
        lb_try(1'b0, 32'(`OFF_CFG_ADDR), 2'b00, 32'h0, rc);
        `CHK("address reg reset", 32'h0, lb_rd)
        // Every device number, random other fields; reserved bits must vanish
        for (int i = 0; i < 16; i++) begin
            av = $random(seed);
            av[14:11] = i[3:0];
            av[0] = 1'b0;
            slow = i[1];
            cfg_cycle(av, i[0]);
        end
        repeat (4) begin
            cfg_cycle($random(seed) | 32'h1, 1'($random(seed)));
        end
        // A second access while one is pending is refused with retry
        slow = 1'b1;
        done_seen = 1'b0;
        lb_try(1'b0, 32'(`OFF_CFG_DATA), 2'b00, 32'h0, rc);
        lb_try(1'b1, 32'(`OFF_CFG_DATA), 2'b00, 32'h5a5a5a5a, rc);
        `CHK("other access retried", 1, rc)
        `CHK("pending command kept", `CMD_CFG_RD, cmd)
        lb_until_ack(1'b0, 32'(`OFF_CFG_DATA), 2'b00, 32'h0);
        // Master enable clear gives bus errors and no cycle
        men = 1'b0;
        lb_try(1'b0, 32'(`OFF_CFG_DATA), 2'b00, 32'h0, rc);
        `CHK("data reg bus error", 2, rc)
        lb_try(1'b0, 32'(`OFF_INTACK), 2'b00, 32'h0, rc);
        `CHK("vector reg bus error", 2, rc)
        `CHK("no cycle without enable", 1'b0, preq)
        men = 1'b1;
        // Intack reads of every size carry the local address
        for (int s = 0; s < 4; s++) begin
            vec = $random(seed);
            av = {20'($random(seed)), `OFF_INTACK};
            lb_delayed(1'b0, av, 2'(s), 32'h0);
            `CHK("intack command", `CMD_INTACK, scmd)
            `CHK("intack lanes", (s == 0) ? 4 : s, $countones(sbe))
            `CHK("intack address", av, pa)
            `CHK("intack vector", vec, lb_rd)
        end
        lb_try(1'b1, 32'(`OFF_INTACK), 2'b00, 32'hffffffff, rc);
        `CHK("vector write ignored", 0, rc)
        `CHK("no intack on write", 1'b0, preq)
        pr_access(1'b1, `OFF_CFG_DATA);
        pr_access(1'b0, `OFF_CFG_DATA);
        `CHK("pci side data read", 32'h0, pr_rd)
        pr_access(1'b1, `OFF_INTACK);
        pr_access(1'b0, `OFF_INTACK);
        `CHK("pci side vector read", 32'h0, pr_rd)
        // Packet fetch reloads the pointer, low nibble dropped
        pkt_nx = $random(seed);
        pkt_ld = 1'b1;
        @(negedge clk);
        pkt_ld = 1'b0;
        lb_try(1'b0, 32'(`OFF_PKT_PTR), 2'b00, 32'h0, rc);
        `CHK("packet pointer", pkt_nx & `PKT_PTR_MASK, lb_rd)
        // Flags stick after the event and clear on a written one
        ev = {16'($random(seed)) | 16'h1, 16'h0};
        av = ev;
        @(negedge clk);
        ev = 32'h0;
        repeat (3) @(negedge clk);
        `CHK("flags set and held", `INT_FLAGS_RESET | av, flags)
        `CHK("flag bits present", 1'b1, |(flags & av))
        lb_try(1'b1, 32'(`OFF_INT_FLAGS), 2'b00, av, rc);
        @(negedge clk);
        `CHK("flags cleared", `INT_FLAGS_RESET, flags)
        lb_try(1'b0, 32'h7fc, 2'b00, 32'h0, rc);
        `CHK("unmapped read zero", 32'h0, lb_rd)
        conclude();
    end
endmodule
`default_nettype wire
